// ---- rtl/jtr_pkg.sv ----
/*
 * constants, types and state encoding for the boundary-scan port block.
 * assumes a single 100 MHz system clock samples every test-port pin.
 */
package jtr_pkg;

   // ------------------------------------------------------------
   // widths and instruction codes
   // ------------------------------------------------------------
   localparam int          IR_W      = 4;
   localparam int          DR_W      = 32;
   localparam logic [3:0]  IR_IDCODE = 4'h1;
   localparam logic [3:0]  IR_BYPASS = 4'hF;
   localparam logic [3:0]  IR_CAP    = 4'h1;  // capture-ir pattern, ends 01
   // value is arbitrary, names no real part
   localparam logic [31:0] ID_VALUE  = 32'h1234_5001;
   localparam int          SYNC_LEN  = 2;      // flops per pin synchroniser

   // ------------------------------------------------------------
   // tap controller states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
      ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
      ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } jtr_state_t;

   // ------------------------------------------------------------
   // pin group carried through the synchroniser
   // ------------------------------------------------------------
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jtr_pins_t;

endpackage

// ---- rtl/jtr_tap.sv ----
/*
 * boundary-scan test access port of the bridge: tap controller,
 * instruction register, identification and bypass data registers.
 * assumes the tester's test clock is slow against the 100 MHz system
 * clock (bench period 160 ns), so every pin is sampled and tck edges
 * are found by comparing successive synchronised samples.
 */
`timescale 1ns/1ps

module jtr_tap
(
   input  wire logic              clock,      // system clock, 100 MHz
   input  wire logic              rst,        // synchronous, active high
   input  wire logic              tck,        // test clock pin
   input  wire logic              tms,        // mode select pin level
   input  wire logic              tms_drv,    // high while tester drives tms
   input  wire logic              tdi,        // serial input pin level
   input  wire logic              tdi_drv,    // high while tester drives tdi
   input  wire logic              trst_n,     // tap reset and disable, low
   output logic                   tdo,        // serial output level
   output logic                   tdo_oe,     // high while tdo is driven
   output logic                   test_en,    // test function enabled
   output jtr_pkg::jtr_state_t    tap_state,  // controller state
   output logic [3:0]             ir_out      // active instruction
);

   // ------------------------------------------------------------
   // pin conditioning and synchronisers
   // ------------------------------------------------------------
   // undriven lines float to the internal pull-up level
   jtr_pkg::jtr_pins_t pins_raw;
   jtr_pkg::jtr_pins_t sync1_r;
   jtr_pkg::jtr_pins_t sync2_r;
   logic               tck_prev_r;

   assign pins_raw.tck    = tck;
   assign pins_raw.tms    = tms_drv ? tms : 1'b1;
   assign pins_raw.tdi    = tdi_drv ? tdi : 1'b1;
   assign pins_raw.trst_n = trst_n;

   // two flops per pin; the first is read by the second only
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sync1_r    <= '0;
         sync2_r    <= '0;
         tck_prev_r <= 1'b0;
      end
      else
      begin
         sync1_r    <= pins_raw;
         sync2_r    <= sync1_r;
         tck_prev_r <= sync2_r.tck;
      end
   end

   // edge detection works on the second stage, never the first
   wire tck_rise  = sync2_r.tck & ~tck_prev_r;
   wire tck_fall  = ~sync2_r.tck & tck_prev_r;
   wire s_tms     = sync2_r.tms;
   wire s_tdi     = sync2_r.tdi;
   wire trst_low  = ~sync2_r.trst_n;

   // ------------------------------------------------------------
   // controller next state
   // ------------------------------------------------------------
   jtr_pkg::jtr_state_t state_r;
   jtr_pkg::jtr_state_t state_nxt;

   // mode select is the only steering input
   always_comb
   begin
      case (state_r)
         jtr_pkg::ST_RESET:
            state_nxt = s_tms ? jtr_pkg::ST_RESET : jtr_pkg::ST_IDLE;
         jtr_pkg::ST_IDLE:
            state_nxt = s_tms ? jtr_pkg::ST_SEL_DR : jtr_pkg::ST_IDLE;
         jtr_pkg::ST_SEL_DR:
            state_nxt = s_tms ? jtr_pkg::ST_SEL_IR : jtr_pkg::ST_CAP_DR;
         jtr_pkg::ST_CAP_DR:
            state_nxt = s_tms ? jtr_pkg::ST_EXIT1_DR
                              : jtr_pkg::ST_SHIFT_DR;
         jtr_pkg::ST_SHIFT_DR:
            state_nxt = s_tms ? jtr_pkg::ST_EXIT1_DR
                              : jtr_pkg::ST_SHIFT_DR;
         jtr_pkg::ST_EXIT1_DR:
            state_nxt = s_tms ? jtr_pkg::ST_UPD_DR : jtr_pkg::ST_PAUSE_DR;
         jtr_pkg::ST_PAUSE_DR:
            state_nxt = s_tms ? jtr_pkg::ST_EXIT2_DR
                              : jtr_pkg::ST_PAUSE_DR;
         jtr_pkg::ST_EXIT2_DR:
            state_nxt = s_tms ? jtr_pkg::ST_UPD_DR : jtr_pkg::ST_SHIFT_DR;
         jtr_pkg::ST_UPD_DR:
            state_nxt = s_tms ? jtr_pkg::ST_SEL_DR : jtr_pkg::ST_IDLE;
         // five high clocks from anywhere end here
         jtr_pkg::ST_SEL_IR:
            state_nxt = s_tms ? jtr_pkg::ST_RESET : jtr_pkg::ST_CAP_IR;
         jtr_pkg::ST_CAP_IR:
            state_nxt = s_tms ? jtr_pkg::ST_EXIT1_IR
                              : jtr_pkg::ST_SHIFT_IR;
         jtr_pkg::ST_SHIFT_IR:
            state_nxt = s_tms ? jtr_pkg::ST_EXIT1_IR
                              : jtr_pkg::ST_SHIFT_IR;
         jtr_pkg::ST_EXIT1_IR:
            state_nxt = s_tms ? jtr_pkg::ST_UPD_IR : jtr_pkg::ST_PAUSE_IR;
         jtr_pkg::ST_PAUSE_IR:
            state_nxt = s_tms ? jtr_pkg::ST_EXIT2_IR
                              : jtr_pkg::ST_PAUSE_IR;
         jtr_pkg::ST_EXIT2_IR:
            state_nxt = s_tms ? jtr_pkg::ST_UPD_IR : jtr_pkg::ST_SHIFT_IR;
         jtr_pkg::ST_UPD_IR:
            state_nxt = s_tms ? jtr_pkg::ST_SEL_DR : jtr_pkg::ST_IDLE;
         default:
            state_nxt = jtr_pkg::ST_RESET;
      endcase
   end

   // tap reset acts on every system clock, test clock or not
   always_ff @(posedge clock)
   begin
      if (rst || trst_low)
         state_r <= jtr_pkg::ST_RESET;
      else if (tck_rise)
         state_r <= state_nxt;
   end

   // ------------------------------------------------------------
   // instruction and data registers
   // ------------------------------------------------------------
   logic [3:0]  ir_r;
   logic [3:0]  ir_sh_r;
   logic [31:0] dr_sh_r;

   wire in_reset  = (state_r == jtr_pkg::ST_RESET);
   wire sel_byp   = (ir_r == jtr_pkg::IR_BYPASS);
   wire cap_dr    = (state_r == jtr_pkg::ST_CAP_DR);
   wire shift_dr  = (state_r == jtr_pkg::ST_SHIFT_DR);
   wire cap_ir    = (state_r == jtr_pkg::ST_CAP_IR);
   wire shift_ir  = (state_r == jtr_pkg::ST_SHIFT_IR);
   wire upd_ir    = (state_r == jtr_pkg::ST_UPD_IR);
   // bypass is one bit long: new bit lands in bit 0
   wire [31:0] dr_shifted = sel_byp ? {31'h0, s_tdi}
                                    : {s_tdi, dr_sh_r[31:1]};
   wire [31:0] dr_capture = sel_byp ? 32'h0000_0000 : jtr_pkg::ID_VALUE;

   // the reset state loads idcode and clears both shift registers at once
   always_ff @(posedge clock)
   begin
      if (rst || trst_low || in_reset)
      begin
         ir_r    <= jtr_pkg::IR_IDCODE;
         ir_sh_r <= '0;
         dr_sh_r <= '0;
      end
      else if (tck_rise)
      begin
         if (cap_ir)
            ir_sh_r <= jtr_pkg::IR_CAP;
         else if (shift_ir)
            ir_sh_r <= {s_tdi, ir_sh_r[3:1]};
         if (upd_ir)
            ir_r <= ir_sh_r;
         if (cap_dr)
            dr_sh_r <= dr_capture;
         else if (shift_dr)
            dr_sh_r <= dr_shifted;
      end
   end

   // ------------------------------------------------------------
   // serial output and enable
   // ------------------------------------------------------------
   logic tdo_r;
   logic tdo_oe_r;
   logic test_en_r;

   wire shifting = shift_dr | shift_ir;
   wire tdo_bit  = shift_ir ? ir_sh_r[0] : dr_sh_r[0];

   // output moves half a test clock after capture, so the tester
   // samples a settled level on the following rise
   always_ff @(posedge clock)
   begin
      if (rst || trst_low)
      begin
         tdo_r    <= 1'b1;
         tdo_oe_r <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_r    <= shifting ? tdo_bit : 1'b1;
         tdo_oe_r <= shifting;
      end
   end

   // disable follows the synchronised reset level
   always_ff @(posedge clock)
   begin
      if (rst)
         test_en_r <= 1'b0;
      else
         test_en_r <= ~trst_low;
   end

   assign tdo       = tdo_r;
   assign tdo_oe    = tdo_oe_r;
   assign test_en   = test_en_r;
   assign tap_state = state_r;
   assign ir_out    = ir_r;

endmodule // jtr_tap

// ---- sim/jtr_tap_monitor.sv ----
/*
 * concurrent checks on the boundary-scan port's pins.
 * assumes it is bound to jtr_tap and sees only its ports.
 */
`timescale 1ns/1ps

module jtr_tap_monitor
(
   input wire logic                clock,     // system clock
   input wire logic                rst,       // synchronous reset
   input wire logic                tck,       // test clock pin
   input wire logic                tms,       // mode select
   input wire logic                tms_drv,   // mode select driven
   input wire logic                tdi,       // serial input
   input wire logic                tdi_drv,   // serial input driven
   input wire logic                trst_n,    // tap reset, low
   input wire logic                tdo,       // serial output
   input wire logic                tdo_oe,    // output enable
   input wire logic                test_en,   // test function on
   input wire jtr_pkg::jtr_state_t tap_state, // controller state
   input wire logic [3:0]          ir_out     // instruction
);
   logic [5:0] tck_h_r; // recent test clock samples
   // a mixed history means a test clock edge passed lately
   always_ff @(posedge clock) tck_h_r <= {tck_h_r[4:0], tck};
   wire tck_mix = (tck_h_r != 6'h00) && (tck_h_r != 6'h3f);

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_trst_reset: assert property (!trst_n [*3] |=>
      tap_state == jtr_pkg::ST_RESET) else $error("no reset by trst");
   a_trst_off: assert property (!trst_n [*3] |=> !test_en
      && !tdo_oe && ir_out == jtr_pkg::IR_IDCODE) else $error("not off");
   a_en_on: assert property (trst_n [*4] |=> test_en)
      else $error("test function not enabled");
   a_oe_shift: assert property (tdo_oe |-> tap_state inside
      {jtr_pkg::ST_SHIFT_DR, jtr_pkg::ST_EXIT1_DR, jtr_pkg::ST_SHIFT_IR,
      jtr_pkg::ST_EXIT1_IR}) else $error("tdo driven outside shift");
   a_tdo_idle: assert property (!tdo_oe && trst_n |-> tdo)
      else $error("idle tdo not high");
   a_state_tck: assert property (tap_state != $past(tap_state) &&
      tap_state != jtr_pkg::ST_RESET |-> tck_mix) else $error("no tck");
   a_tdo_tck: assert property (tdo_oe && tdo != $past(tdo) |->
      tck_mix) else $error("tdo moved without tck");
   a_ir_upd: assert property (ir_out != $past(ir_out) |->
      $past(tap_state) inside {jtr_pkg::ST_UPD_IR, jtr_pkg::ST_RESET} ||
      tap_state inside {jtr_pkg::ST_UPD_IR, jtr_pkg::ST_RESET})
      else $error("instruction changed outside update");
   // a floating or high mode select must keep the controller in reset
   a_float_hold: assert property ((!tms_drv || tms) [*3] ##0
      tap_state == jtr_pkg::ST_RESET |=> tap_state == jtr_pkg::ST_RESET)
      else $error("left reset with mode select high");
endmodule // jtr_tap_monitor

bind jtr_tap jtr_tap_monitor mon (.clock(clock), .rst(rst), .tck(tck),
   .tms(tms), .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv),
   .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .test_en(test_en),
   .tap_state(tap_state), .ir_out(ir_out));

// ---- sim/jtr_tester.sv ----
/*
 * behavioural boundary-scan tester driving the port's pins.
 * assumes the bench clock paces it; tck period is 16 clocks.
 */
`timescale 1ns/1ps

module jtr_tester
(
   input  wire logic clock,   // pacing clock
   input  wire logic tdo,     // device serial output
   output logic      tck,     // test clock, still between steps
   output logic      tms,     // mode select level
   output logic      tms_drv, // high while tms driven
   output logic      tdi,     // serial input level
   output logic      tdi_drv, // high while tdi driven
   output logic      trst_n,  // tap reset, low, always driven
   output logic      tdo_s    // tdo seen before the last rise
);
   initial
   begin
      // tap reset held low from power-up until the first pin() call
      {tck, tms, tms_drv, tdi, tdi_drv, trst_n, tdo_s} = 7'h3c;
   end
   // pin levels; tap reset level and the mode-select and serial-input drive flags set as given
   task automatic pin(input logic r, input logic md, input logic dd);
      trst_n = r;
      tms_drv = md;
      tdi_drv = dd;
   endtask
   // one tck period; released lines toggle, never keep a stale value
   task automatic step(input logic m, input logic d);
      tck = 1'b0;
      tms = tms_drv ? m : ~tms;
      tdi = tdi_drv ? d : ~tdi;
      repeat (8) @(posedge clock);
      #1 tdo_s = tdo;
      tck = 1'b1;
      repeat (8) @(posedge clock);
      #1;
   endtask
endmodule // jtr_tester

// ---- sim/test_jtr_tap.sv ----
/*
 * self-checking bench for jtr_tap with a behavioural tester.
 * assumes jtr_pkg, jtr_tap, jtr_tester and the bound monitor.
 */
`timescale 1ns/1ps

module test_jtr_tap;
   logic clock = 1'b0, rst = 1'b1;
   logic tck, tms, tms_drv, tdi, tdi_drv, trst_n, tdo, tdo_oe, test_en, tdo_s;
   jtr_pkg::jtr_state_t tap_state;
   logic [3:0]  ir_out;
   logic [31:0] d;
   int miscompares = 0, n_tests = 0;

   always #5 clock = ~clock;
   jtr_tap uut (.clock(clock), .rst(rst), .tck(tck), .tms(tms),
      .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv), .trst_n(trst_n),
      .tdo(tdo), .tdo_oe(tdo_oe), .test_en(test_en),
      .tap_state(tap_state), .ir_out(ir_out));
   jtr_tester tester (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms),
      .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv), .trst_n(trst_n),
      .tdo_s(tdo_s));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // mode-select sequence, oldest bit first, serial input high
   task automatic go(input logic [7:0] s, input int n);
      for (int i = n - 1; i >= 0; i--)
         tester.step(s[i], 1'b1);
   endtask
   // shift n bits lsb first, leaving with the last bit
   task automatic shift(input int n, input logic [31:0] din);
      d = '0;
      for (int i = 0; i < n; i++)
      begin
         tester.step(i == n - 1, din[i]);
         d[i] = tdo_s;
      end
   endtask
   task automatic t_disable();
      go(8'h00, 2);
      chk(tap_state, jtr_pkg::ST_RESET);
      chk(test_en, 1'b0);
      tester.pin(1'b1, 1'b1, 1'b1);
      repeat (6) @(posedge clock);
      #1 chk(test_en, 1'b1);
      $display("done disable");
   endtask
   // every state visited, ending with five high mode-select clocks
   task automatic t_walk();
      logic [24:0]  m;
      logic [99:0]  e;
      m = 25'h0af_569f;
      e = 100'h1_2356_7829_acde_bcf1_2345_8290;
      for (int i = 24; i >= 0; i--)
      begin
         tester.step(m[i], 1'b1);
         chk(tap_state, e[i*4 +: 4]);
      end
      chk(ir_out, jtr_pkg::IR_IDCODE);
      $display("done walk");
   endtask
   task automatic t_idcode();
      go(8'h04, 4);
      shift(32, 32'h0000_0000);
      go(8'h02, 2);
      chk(d, jtr_pkg::ID_VALUE);
      $display("done idcode");
   endtask
   // instruction shifted from a floating serial input, then bypass
   task automatic t_bypass();
      tester.pin(1'b1, 1'b1, 1'b0);
      go(8'h0c, 4);
      shift(4, 32'h0000_0000);
      go(8'h02, 2);
      tester.pin(1'b1, 1'b1, 1'b1);
      chk(d, jtr_pkg::IR_CAP);
      chk(ir_out, jtr_pkg::IR_BYPASS);
      go(8'h04, 3);
      shift(8, 32'h0000_00a5);
      go(8'h02, 2);
      chk(d, 32'h0000_004a);
      $display("done bypass");
   endtask
   task automatic t_float_tms();
      tester.pin(1'b1, 1'b0, 1'b1);
      go(8'h00, 5);
      chk(tap_state, jtr_pkg::ST_RESET);
      chk(ir_out, jtr_pkg::IR_IDCODE);
      tester.pin(1'b1, 1'b1, 1'b1);
      $display("done float");
   endtask
   // tap reset in mid-shift with the test clock stopped
   task automatic t_trst();
      go(8'h08, 5);
      chk(tdo_oe, 1'b1);
      tester.pin(1'b0, 1'b1, 1'b1);
      repeat (4) @(posedge clock);
      #1 chk(tap_state, jtr_pkg::ST_RESET);
      chk({test_en, tdo_oe, ir_out}, 6'h01);
      go(8'h01, 2);
      chk(tap_state, jtr_pkg::ST_RESET);
      tester.pin(1'b1, 1'b1, 1'b1);
      repeat (6) @(posedge clock);
      #1 go(8'h00, 1);
      $display("done trst");
   endtask

   initial
   begin
      repeat (90000) @(posedge clock);
      miscompares++;
      give_verdict();
   end
   initial
   begin
      repeat (5) @(posedge clock);
      #1 rst = 1'b0;
      t_disable();
      t_walk();
      go(8'h00, 1);
      t_idcode();
      t_bypass();
      t_float_tms();
      go(8'h00, 1);
      t_trst();
      t_idcode();
      give_verdict();
   end
endmodule // test_jtr_tap
